//--- rtl/lef_pkg.sv
// constants shared by the display event flags and contrast value block
package lef_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] CONTRAST_SETUP_ADDR = 32'h0060_0840;
	localparam logic [31:0] CONTRAST_COMPARE_ADDR = 32'h0060_0844;
	localparam logic [31:0] EVENT_ENABLE_SET_ADDR = 32'h0060_0848;
	localparam logic [31:0] EVENT_ENABLE_CLEAR_ADDR = 32'h0060_084c;
	localparam logic [31:0] EVENT_ENABLE_VIEW_ADDR = 32'h0060_0850;
	localparam logic [31:0] EVENT_PENDING_VIEW_ADDR = 32'h0060_0854;
	localparam logic [31:0] EVENT_PENDING_ACK_ADDR = 32'h0060_0858;

	// ----------------------------------------------------------------
	// field widths and positions
	// ----------------------------------------------------------------
	localparam int CMP_W = 8;
	localparam int EVT_W = 7;
	localparam int EV_EVERY_ROW = 0;
	localparam int EV_FINAL_ROW = 1;
	localparam int EV_FRAME_DONE = 2;
	localparam int EV_QUEUE_STARVED = 4;
	localparam int EV_QUEUE_OVERRUN = 5;
	localparam int EV_FETCH_FAULT = 6;
	// bit 3 is a hole in every event register
	localparam logic [EVT_W-1:0] EVT_USED = 7'h77;
	localparam int POLARITY_BIT = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [CMP_W-1:0] CONTRAST_COMPARE_RESET = 8'h00;
	localparam logic [EVT_W-1:0] EVENT_ENABLE_RESET = 7'h00;
	localparam logic [EVT_W-1:0] EVENT_PENDING_RESET = 7'h00;
	localparam logic OUTPUT_POLARITY_RESET = 1'b0;

	// ----------------------------------------------------------------
	// bus response codes
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

//--- rtl/lef_pwm.sv
// contrast pulse-width generator driven by the compare value
`timescale 1ns/100ps
`default_nettype none

module lef_pwm
	import lef_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [CMP_W-1:0] contrast_compare,
	input wire logic output_polarity,
	output logic contrast_out
);

	logic [CMP_W-1:0] count;
	logic [CMP_W-1:0] next_count;
	logic next_contrast_out;
	logic below;

	// ----------------------------------------------------------------
	// counter and comparator
	// ----------------------------------------------------------------
	// free-running counter; compare of zero gives a constant inactive level
	always_comb begin
		next_count = count + 8'h01;
		below = (count < contrast_compare);
		next_contrast_out = output_polarity ? below : ~below;
	end

	// registered so the pin never glitches on the compare
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
			contrast_out <= 1'b0;
		end else begin
			count <= next_count;
			contrast_out <= next_contrast_out;
		end
	end

endmodule

`default_nettype wire

//--- rtl/lef_top.sv
// display event flag bank and contrast compare value behind an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none

module lef_top
	import lef_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// event sources from timing, queue and fetch logic
	input wire logic every_row_event,
	input wire logic final_row_event,
	input wire logic frame_done_event,
	input wire logic queue_starved_event,
	input wire logic queue_overrun_event,
	input wire logic fetch_fault_event,
	// outward signals
	output logic irq,
	output logic contrast_out
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic aw_held;
	logic next_aw_held;
	logic [31:0] aw_addr;
	logic [31:0] next_aw_addr;
	logic next_awready;
	logic w_held;
	logic next_w_held;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0] w_strb;
	logic [3:0] next_w_strb;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic do_write;
	logic low_lane;

	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic ar_take;

	logic [CMP_W-1:0] contrast_compare;
	logic [CMP_W-1:0] next_contrast_compare;
	logic output_polarity;
	logic next_output_polarity;
	logic [EVT_W-1:0] event_allowed;
	logic [EVT_W-1:0] next_event_allowed;
	logic [EVT_W-1:0] event_pending;
	logic [EVT_W-1:0] next_event_pending;
	logic [EVT_W-1:0] event_in;
	logic [EVT_W-1:0] wr_bits;
	logic next_irq;

	// ----------------------------------------------------------------
	// address decode helpers
	// ----------------------------------------------------------------
	// every mapped register, readable or not; the rest get decerr
	function automatic logic is_mapped(input logic [31:0] addr);
		is_mapped = (addr == CONTRAST_SETUP_ADDR) ||
			(addr == CONTRAST_COMPARE_ADDR) ||
			(addr == EVENT_ENABLE_SET_ADDR) ||
			(addr == EVENT_ENABLE_CLEAR_ADDR) ||
			(addr == EVENT_ENABLE_VIEW_ADDR) ||
			(addr == EVENT_PENDING_VIEW_ADDR) ||
			(addr == EVENT_PENDING_ACK_ADDR);
	endfunction

	// ----------------------------------------------------------------
	// event vector
	// ----------------------------------------------------------------
	// hole at bit 3 is tied low so it can never become pending
	always_comb begin
		event_in = '0;
		event_in[EV_EVERY_ROW] = every_row_event;
		event_in[EV_FINAL_ROW] = final_row_event;
		event_in[EV_FRAME_DONE] = frame_done_event;
		event_in[EV_QUEUE_STARVED] = queue_starved_event;
		event_in[EV_QUEUE_OVERRUN] = queue_overrun_event;
		event_in[EV_FETCH_FAULT] = fetch_fault_event;
	end

	// ----------------------------------------------------------------
	// write channels
	// ----------------------------------------------------------------
	// address and data are caught independently, in either order;
	// the write fires once both are held and no response is pending
	always_comb begin
		do_write = aw_held && w_held && !bvalid;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = is_mapped(aw_addr) ? RESP_OKAY : RESP_DECERR;
		end
		next_awready = !next_aw_held;
		next_wready = !next_w_held;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			awready <= 1'b0;
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			awready <= next_awready;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
		end
	end

	// ----------------------------------------------------------------
	// read channels
	// ----------------------------------------------------------------
	// one read in flight; data returns the cycle after the address
	always_comb begin
		ar_take = arvalid && arready;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
		if (ar_take) begin
			next_rvalid = 1'b1;
			next_rdata = '0;
			next_rresp = RESP_OKAY;
			unique case (araddr)
				CONTRAST_SETUP_ADDR: begin
					next_rdata[POLARITY_BIT] = output_polarity;
				end
				CONTRAST_COMPARE_ADDR: begin
					next_rdata[CMP_W-1:0] = contrast_compare;
				end
				EVENT_ENABLE_VIEW_ADDR: begin
					next_rdata[EVT_W-1:0] = event_allowed & EVT_USED;
				end
				EVENT_PENDING_VIEW_ADDR: begin
					next_rdata[EVT_W-1:0] = event_pending & EVT_USED;
				end
				EVENT_ENABLE_SET_ADDR, EVENT_ENABLE_CLEAR_ADDR,
				EVENT_PENDING_ACK_ADDR: begin
					// write-only registers read back zero
					next_rdata = '0;
				end
				default: begin
					next_rresp = RESP_DECERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// ----------------------------------------------------------------
	// register file and interrupt
	// ----------------------------------------------------------------
	// all writable fields live in byte lane 0, so only that lane matters;
	// a hardware event in the same cycle as its ack wins over the ack
	always_comb begin
		low_lane = do_write && w_strb[0];
		wr_bits = w_data[EVT_W-1:0] & EVT_USED;
		next_contrast_compare = contrast_compare;
		next_output_polarity = output_polarity;
		next_event_allowed = event_allowed;
		next_event_pending = event_pending;
		if (low_lane) begin
			unique case (aw_addr)
				CONTRAST_SETUP_ADDR: begin
					next_output_polarity = w_data[POLARITY_BIT];
				end
				CONTRAST_COMPARE_ADDR: begin
					next_contrast_compare = w_data[CMP_W-1:0];
				end
				EVENT_ENABLE_SET_ADDR: begin
					next_event_allowed = event_allowed | wr_bits;
				end
				EVENT_ENABLE_CLEAR_ADDR: begin
					next_event_allowed = event_allowed & ~wr_bits;
				end
				EVENT_PENDING_ACK_ADDR: begin
					next_event_pending = event_pending & ~wr_bits;
				end
				default: begin
					// read-only or unmapped: writes have no effect
					next_event_pending = event_pending;
				end
			endcase
		end
		next_event_pending = next_event_pending | (event_in & EVT_USED);
		next_irq = |(next_event_pending & next_event_allowed);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			contrast_compare <= CONTRAST_COMPARE_RESET;
			output_polarity <= OUTPUT_POLARITY_RESET;
			event_allowed <= EVENT_ENABLE_RESET;
			event_pending <= EVENT_PENDING_RESET;
			irq <= 1'b0;
		end else begin
			contrast_compare <= next_contrast_compare;
			output_polarity <= next_output_polarity;
			event_allowed <= next_event_allowed;
			event_pending <= next_event_pending;
			irq <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// contrast generator
	// ----------------------------------------------------------------
	lef_pwm u_pwm (
		.aclk(aclk),
		.aresetn(aresetn),
		.contrast_compare(contrast_compare),
		.output_polarity(output_polarity),
		.contrast_out(contrast_out)
	);

endmodule

`default_nettype wire

//--- verification/lcd_event_flags_and_contrast_value_tb_top.sv
// self-checking bench for the display event flag block
`timescale 1ns/100ps
`default_nettype none

module lcd_event_flags_and_contrast_value_tb_top
	import lef_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq, cout;
	logic [1:0] bresp, rresp;
	logic [6:0] ev = '0;
	int errors = 0, check_count = 0, cycles = 0;

	always #5 aclk = ~aclk;

	lef_top dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
		.wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .every_row_event(ev[0]),
		.final_row_event(ev[1]), .frame_done_event(ev[2]), .queue_starved_event(ev[4]),
		.queue_overrun_event(ev[5]), .fetch_fault_event(ev[6]), .irq, .contrast_out(cout));

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ready raised a cycle late so a waiting answer is exercised
	task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
		check(bresp, r);
	endtask

	task automatic axr(input logic [31:0] a, e, input logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		check(rdata, e);
		check(rresp, r);
	endtask

	task automatic pulse(input int i);
		@(posedge aclk);
		ev[i] <= 1'b1;
		@(posedge aclk);
		ev[i] <= 1'b0;
		@(posedge aclk);
	endtask

	// a full 256-cycle period gives an exact count whatever the phase
	task automatic duty(input logic [31:0] e);
		logic [31:0] n;
		n = 0;
		repeat (2) @(posedge aclk);
		repeat (256) begin
			@(posedge aclk);
			n = n + cout;
		end
		check(n, e);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_rst();
		axr(CONTRAST_COMPARE_ADDR, 32'h0, RESP_OKAY);
		axr(EVENT_ENABLE_VIEW_ADDR, 32'h0, RESP_OKAY);
		axr(EVENT_PENDING_VIEW_ADDR, 32'h0, RESP_OKAY);
		check(irq, 1'b0);
	endtask

	task automatic t_cmp();
		axw(CONTRAST_COMPARE_ADDR, 32'hffff_ffa5, RESP_OKAY);
		axr(CONTRAST_COMPARE_ADDR, 32'h0000_00a5, RESP_OKAY);
	endtask

	task automatic t_evt();
		for (int i = 0; i < 7; i++) begin
			if (i != 3) begin
				pulse(i);
				axr(EVENT_PENDING_VIEW_ADDR, 32'h1 << i, RESP_OKAY);
				check(irq, 1'b0);
				axw(EVENT_PENDING_ACK_ADDR, ~(32'h1 << i), RESP_OKAY);
				axr(EVENT_PENDING_VIEW_ADDR, 32'h1 << i, RESP_OKAY);
				axw(EVENT_PENDING_ACK_ADDR, 32'h1 << i, RESP_OKAY);
				axr(EVENT_PENDING_VIEW_ADDR, 32'h0, RESP_OKAY);
			end
		end
	endtask

	task automatic t_msk();
		axw(EVENT_ENABLE_SET_ADDR, 32'hffff_ffff, RESP_OKAY);
		axr(EVENT_ENABLE_VIEW_ADDR, 32'h77, RESP_OKAY);
		axw(EVENT_ENABLE_CLEAR_ADDR, 32'h5, RESP_OKAY);
		axr(EVENT_ENABLE_VIEW_ADDR, 32'h72, RESP_OKAY);
		pulse(1);
		check(irq, 1'b1);
		axw(EVENT_ENABLE_CLEAR_ADDR, 32'h2, RESP_OKAY);
		check(irq, 1'b0);
		axw(EVENT_ENABLE_SET_ADDR, 32'h2, RESP_OKAY);
		axr(EVENT_ENABLE_VIEW_ADDR, 32'h72, RESP_OKAY);
		check(irq, 1'b1);
		axw(EVENT_PENDING_ACK_ADDR, 32'h2, RESP_OKAY);
		check(irq, 1'b0);
	endtask

	task automatic t_bus();
		axw(32'h0060_085c, 32'h1, RESP_DECERR);
		axr(32'h0060_085c, 32'h0, RESP_DECERR);
		axr(EVENT_ENABLE_SET_ADDR, 32'h0, RESP_OKAY);
		axw(EVENT_PENDING_VIEW_ADDR, 32'h7f, RESP_OKAY);
		axr(EVENT_PENDING_VIEW_ADDR, 32'h0, RESP_OKAY);
	endtask

	task automatic t_pwm();
		axw(CONTRAST_COMPARE_ADDR, 32'h40, RESP_OKAY);
		duty(32'd192);
		axw(CONTRAST_SETUP_ADDR, 32'h1 << POLARITY_BIT, RESP_OKAY);
		axr(CONTRAST_SETUP_ADDR, 32'h1 << POLARITY_BIT, RESP_OKAY);
		duty(32'd64);
	endtask

	// reset in mid-run with an interrupt up must wipe every register
	task automatic t_rrst();
		axw(EVENT_ENABLE_SET_ADDR, 32'h1, RESP_OKAY);
		pulse(0);
		check(irq, 1'b1);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_rst();
		axr(CONTRAST_SETUP_ADDR, 32'h0, RESP_OKAY);
		duty(32'd256);
	endtask

	// hang guard, far above the roughly 1100 cycles needed
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_rst();
		t_cmp();
		t_evt();
		t_msk();
		t_bus();
		t_pwm();
		t_rrst();
		report_and_stop();
	end
endmodule
`default_nettype wire

//--- verification/lef_asserts.sv
// port-level assertions for the display event flag block
`timescale 1ns/100ps
`default_nettype none

module lef_asserts
	import lef_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic every_row_event,
	input wire logic final_row_event,
	input wire logic frame_done_event,
	input wire logic queue_starved_event,
	input wire logic queue_overrun_event,
	input wire logic fetch_fault_event,
	input wire logic irq
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [31:0] ra, next_ra;
	logic [5:0] evs;
	// keep the read address, the master drops it once taken
	always_comb next_ra = (arvalid && arready) ? araddr : ra;
	always_ff @(posedge aclk) ra <= next_ra;
	assign evs = {every_row_event, final_row_event, frame_done_event,
		queue_starved_event, queue_overrun_event, fetch_fault_event};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_reset_idle: assert property ($rose(aresetn) |-> !irq && !bvalid && !rvalid)
		else $error("outputs busy after reset");
	chk_irq_cause: assert property ($rose(irq) |-> $past(|evs) || $rose(bvalid))
		else $error("irq rose without event or write");
	chk_irq_drop: assert property ($fell(irq) |-> $rose(bvalid))
		else $error("irq fell without a write");
	chk_event_holes: assert property (rvalid && (ra == EVENT_ENABLE_VIEW_ADDR ||
		ra == EVENT_PENDING_VIEW_ADDR) |-> rdata[31:7] == 25'h0 && !rdata[3])
		else $error("unused event bit read as one");
	chk_compare_width: assert property (rvalid && ra == CONTRAST_COMPARE_ADDR |-> rdata[31:8] == 24'h0)
		else $error("compare value wider than a byte");
	chk_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");

	cover property ($rose(irq));
	cover property (bvalid && bresp == RESP_DECERR);
	cover property (rvalid && !rready);
endmodule

bind lef_top lef_asserts chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
	.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready,
	.every_row_event, .final_row_event, .frame_done_event, .queue_starved_event,
	.queue_overrun_event, .fetch_fault_event, .irq);
`default_nettype wire
